// [ucdpc_top.sv]
// Charger detection on the upstream port and charging control on the downstream ports.
// Assumes register strobes come from the serial register file on core_clk, and that the
// analog comparators, strap pins and over-current pins are asynchronous to core_clk.
`timescale 1ns/1ps
module ucdpc_top
  import ucdpc_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 4,
  parameter int unsigned TICK_CYCLES = TICK_CYC
)(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Hub stage and status from hub logic
  input  wire logic                 charger_detect_stage,
  input  wire logic                 wait_reference_clock_in_stage,
  input  wire logic                 reference_clock_in_running,
  input  wire logic                 hw_init_done,
  input  wire logic                 host_connected,
  input  wire logic                 ganged_power,
  input  wire logic [NUM_PORTS:1]   host_port_power,
  // Pins
  input  wire logic [NUM_PORTS:1]   charge_enable_strap,
  input  wire logic [NUM_PORTS:1]   overcurrent_sense_n,
  input  wire ucdpc_cmp_t           cmp_in,
  output ucdpc_drive_t              line_drive,
  output logic [NUM_PORTS:1]        port_power_out,
  output logic                      charger_irq,
  // Register access from the serial interface
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata
);

  if (NUM_PORTS < 1 || NUM_PORTS > 7)
    $error("NUM_PORTS must be 1..7");
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65536)
    $error("TICK_CYCLES must be 2..65536");

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned SYNC_W = $bits(ucdpc_cmp_t) + 2 * NUM_PORTS;
  // Sense pins idle high; a low reset value would fake a fault on every port
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(SYNC_W-NUM_PORTS){1'b0}}, {NUM_PORTS{1'b1}}};

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] filt_reg;

  // A change is accepted once the last two stages agree
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      sync3_reg <= SYNC_IDLE;
      filt_reg  <= SYNC_IDLE;
    end
    else
    begin
      sync1_reg <= {cmp_in, charge_enable_strap, overcurrent_sense_n};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < SYNC_W; i++)
        if (sync2_reg[i] == sync3_reg[i])
          filt_reg[i] <= sync3_reg[i];
    end
  end

  ucdpc_cmp_t           cmp_s;
  logic [NUM_PORTS:1]   strap_s;
  logic [NUM_PORTS:1]   oc_s;

  assign cmp_s   = filt_reg[SYNC_W-1 -: $bits(ucdpc_cmp_t)];
  assign strap_s = filt_reg[2*NUM_PORTS-1 -: NUM_PORTS];
  assign oc_s    = ~filt_reg[NUM_PORTS-1:0];

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0]          det_ctrl_reg;
  logic [7:0]          custom_reg;
  logic [NUM_PORTS:1]  chg_en_reg;
  logic [2:0]          strap_wait_reg;
  logic                class_lock_reg;
  logic                wr_chg_en;
  logic                wr_ctrl;

  assign wr_chg_en = reg_wr && reg_addr == REG_CHG_EN;
  assign wr_ctrl   = reg_wr && reg_addr == REG_DET_CTRL;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      det_ctrl_reg <= DET_CTRL_RESET;
      custom_reg   <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        det_ctrl_reg <= {1'b0, reg_wdata[6:0]};
      if (reg_wr && reg_addr == REG_CUSTOM)
        custom_reg <= reg_wdata;
    end
  end

  // Straps are caught once the synchronisers have filled after reset release
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_wait_reg <= 3'h0;
      chg_en_reg     <= '0;
      class_lock_reg <= 1'b0;
    end
    else
    begin
      if (strap_wait_reg != 3'h5)
        strap_wait_reg <= strap_wait_reg + 3'h1;
      if (strap_wait_reg == 3'h4)
        chg_en_reg <= strap_s;
      else if (wr_chg_en && !class_lock_reg)
        chg_en_reg <= reg_wdata[NUM_PORTS:1];
      if (hw_init_done && strap_wait_reg == 3'h5)
        class_lock_reg <= 1'b1;
    end
  end

  // ****************************************
  // Upstream detection state machine
  // ****************************************
  ucdpc_det_state_t state_reg;
  logic [15:0]      settle_reg;
  logic [2:0]       type_reg;
  logic             done_reg;
  logic             allow_reg;
  logic             det_allow;
  logic             custom_on;
  logic [2:0]       type_next;

  assign custom_on = custom_reg[CUS_EN_BIT];
  // The oscillator option lets a dead-battery system detect before the reference_clock_in arrives
  assign det_allow = det_ctrl_reg[CTL_EN_BIT] && !custom_on &&
                     (charger_detect_stage ||
                      (wait_reference_clock_in_stage && det_ctrl_reg[CTL_OSC_BIT]));

  always_comb
  begin
    type_next = TYPE_NONE;
    if (cmp_s.dp_at_high && cmp_s.dm_at_mid)
      type_next = TYPE_PROP_SUPER;
    else if (cmp_s.dp_at_mid && cmp_s.dm_at_high)
      type_next = TYPE_PROP_HIGH;
    else if (cmp_s.dp_at_mid && cmp_s.dm_at_mid)
      type_next = TYPE_PROP_LOW;
    else if (cmp_s.dp_dm_short)
      type_next = TYPE_DCP;
    else if (cmp_s.dm_reflects_dp && det_ctrl_reg[CTL_ENH_BIT])
      type_next = TYPE_CDP;
    else if (cmp_s.both_pulled_down)
      type_next = TYPE_SDP;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg  <= DET_IDLE;
      settle_reg <= 16'h0000;
      type_reg   <= TYPE_NONE;
      done_reg   <= 1'b0;
      allow_reg  <= 1'b0;
    end
    else
    begin
      allow_reg <= det_allow;
      case (state_reg)
        DET_IDLE:
          if (det_allow && !allow_reg)
          begin
            state_reg  <= DET_SETTLE;
            settle_reg <= 16'(SETTLE_CYC - 1);
            type_reg   <= TYPE_NONE;
            done_reg   <= 1'b0;
          end
        DET_SETTLE:
          if (!det_allow)
            state_reg <= DET_IDLE;
          else if (settle_reg != 16'h0000)
            settle_reg <= settle_reg - 16'h0001;
          else
          begin
            type_reg  <= type_next;
            done_reg  <= 1'b1;
            state_reg <= DET_DONE;
          end
        DET_DONE:
          if (!det_allow)
            state_reg <= DET_IDLE;
        default:
          state_reg <= DET_IDLE;
      endcase
    end
  end

  // Sources on the data pair: software control while custom is enabled, else automatic during settle and off otherwise
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      line_drive <= '0;
    else if (custom_on)
      line_drive <= custom_reg[4:1];
    else if (state_reg == DET_SETTLE)
      line_drive <= '{dp_src: 1'b1, dm_src: 1'b0, dp_sink: 1'b0, dm_sink: 1'b1};
    else
      line_drive <= '0;
  end

  // Interrupt: a new result wins over a clear in the same cycle
  logic done_rise;
  assign done_rise = (state_reg == DET_SETTLE) && det_allow && settle_reg == 16'h0000;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      charger_irq <= 1'b0;
    else if (done_rise)
      charger_irq <= 1'b1;
    else if (wr_ctrl && reg_wdata[CTL_CLR_BIT])
      charger_irq <= 1'b0;
  end

  // ****************************************
  // Register read-back
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else
      case (reg_addr)
        REG_CHG_EN:  reg_rdata <= 8'({chg_en_reg, 1'b0});
        REG_STATUS:  reg_rdata <= {3'h0, charger_irq, done_reg, type_reg};
        REG_DET_CTRL: reg_rdata <= det_ctrl_reg;
        REG_CUSTOM:  reg_rdata <= custom_reg;
        REG_COMPARE: reg_rdata <= 8'({cmp_s});
        default:     reg_rdata <= 8'h00;
      endcase
  end

  // ****************************************
  // Downstream power and over-current retry
  // ****************************************
  logic [15:0] tick_cnt_reg;
  logic        tick_reg;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_cnt_reg == 16'(TICK_CYCLES - 1);
      if (tick_cnt_reg == 16'(TICK_CYCLES - 1))
        tick_cnt_reg <= 16'h0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Ganged mode feeds every timer the same fault, so all charging-enabled ports drop together
  logic any_oc;
  assign any_oc = |(oc_s & chg_en_reg);

  genvar p;
  generate
    for (p = 1; p <= NUM_PORTS; p++)
    begin : g_port
      logic        off_reg;
      logic [13:0] off_ms_reg;
      logic [1:0]  tries_reg;
      logic [1:0]  clean_reg;
      logic        dcp_mode;
      logic        fault;

      assign dcp_mode = chg_en_reg[p] && !host_connected && hw_init_done;
      assign fault    = ganged_power ? any_oc : oc_s[p];

      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          off_reg    <= 1'b0;
          off_ms_reg <= 14'h0000;
          tries_reg  <= 2'h0;
          clean_reg  <= 2'h0;
        end
        else if (!dcp_mode)
        begin
          off_reg   <= 1'b0;
          tries_reg <= 2'h0;
          clean_reg <= 2'h0;
        end
        else if (off_reg)
        begin
          if (tick_reg)
            off_ms_reg <= off_ms_reg - 14'h0001;
          if (tick_reg && off_ms_reg == 14'h0001)
            off_reg <= 1'b0;
        end
        else if (fault)
        begin
          off_reg   <= 1'b1;
          clean_reg <= 2'h0;
          if (tries_reg < 2'(RETRY_FAST_MAX))
          begin
            off_ms_reg <= 14'(RETRY_SHORT_MS);
            tries_reg  <= tries_reg + 2'h1;
          end
          else
            off_ms_reg <= 14'(RETRY_LONG_MS);
        end
        // Sense lags power by the synchroniser: forget tries only after three clean ticks
        else if (clean_reg != 2'h3)
        begin
          if (tick_reg)
            clean_reg <= clean_reg + 2'h1;
        end
        else
          tries_reg <= 2'h0;
      end

      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
          port_power_out[p] <= 1'b0;
        else if (!chg_en_reg[p] || host_connected)
          port_power_out[p] <= host_port_power[p];
        else
          port_power_out[p] <= hw_init_done && !off_reg && !fault;
      end

      a_dcp_off_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(off_reg) |-> !port_power_out[p] [*2]) else $error("power on during retry");
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_auto_start: assert property (det_allow && !allow_reg && state_reg == DET_IDLE
    |=> state_reg == DET_SETTLE && line_drive == '0) else $error("no auto start");
  a_settle_drive: assert property (state_reg == DET_SETTLE && $past(state_reg) == DET_SETTLE
    |-> line_drive.dp_src || custom_on) else $error("no line drive");
  a_type_cdp: assert property (done_rise && !det_ctrl_reg[CTL_ENH_BIT]
    |=> type_reg != TYPE_CDP) else $error("cdp without enhanced");
  a_type_dcp: assert property (done_rise && cmp_s.dp_dm_short && !cmp_s.dp_at_mid
    && !cmp_s.dp_at_high |=> type_reg == TYPE_DCP) else $error("short not 001");
  a_irq_done: assert property (done_rise |=> charger_irq && done_reg)
    else $error("irq missing");
  a_custom_drive: assert property (custom_on |=> line_drive == $past(custom_reg[4:1]))
    else $error("custom drive ignored");
  a_lock_hold: assert property (class_lock_reg && strap_wait_reg == 3'h5
    |=> $stable(chg_en_reg)) else $error("class changed");
  a_type_idle: assert property (!done_reg |-> type_reg == TYPE_NONE)
    else $error("type without result");
  a_gang_drop: assert property (ganged_power && any_oc && !host_connected
    && hw_init_done |=> (port_power_out & chg_en_reg) == '0) else $error("gang on");

  c_det_done: cover property (done_rise);
  c_type_prop: cover property (done_rise ##1 type_reg == TYPE_PROP_SUPER);
  c_retry: cover property ($rose(g_port[1].off_reg) ##[1:5] g_port[1].off_reg);

endmodule : ucdpc_top

// [ucdpc_pkg.sv]
// Package for the charger detection and downstream port charging block.
// Assumes a single 20 MHz core clock; all timing counts derive from it.
package ucdpc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SETTLE_US       = 40;
  localparam int unsigned SETTLE_CYC      = CLK_HZ / 1_000_000 * SETTLE_US;
  localparam int unsigned RETRY_SHORT_MS  = 1000;
  localparam int unsigned RETRY_LONG_MS   = 10000;
  localparam int unsigned RETRY_FAST_MAX  = 3;

  // ****************************************
  // Register indices and fields
  // ****************************************
  localparam logic [7:0] REG_CHG_EN      = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h01;
  localparam logic [7:0] REG_DET_CTRL    = 8'h02;
  localparam logic [7:0] REG_CUSTOM      = 8'h03;
  localparam logic [7:0] REG_COMPARE     = 8'h04;
  localparam logic [7:0] CHG_EN_RESET    = 8'h00;
  localparam logic [7:0] DET_CTRL_RESET  = 8'h01;
  localparam int unsigned ST_DONE_BIT    = 3;
  localparam int unsigned ST_IRQ_BIT     = 4;
  localparam int unsigned CTL_EN_BIT     = 0;
  localparam int unsigned CTL_ENH_BIT    = 1;
  localparam int unsigned CTL_OSC_BIT    = 2;
  localparam int unsigned CTL_CLR_BIT    = 7;
  localparam int unsigned CUS_EN_BIT     = 0;

  // ****************************************
  // Charger type codes
  // ****************************************
  localparam logic [2:0] TYPE_NONE       = 3'h0;
  localparam logic [2:0] TYPE_DCP        = 3'h1;
  localparam logic [2:0] TYPE_CDP        = 3'h2;
  localparam logic [2:0] TYPE_SDP        = 3'h3;
  localparam logic [2:0] TYPE_PROP_LOW   = 3'h4;
  localparam logic [2:0] TYPE_PROP_HIGH  = 3'h5;
  localparam logic [2:0] TYPE_PROP_SUPER = 3'h6;

  // Comparator results from the analog front end
  typedef struct packed {
    logic dp_dm_short;
    logic dm_reflects_dp;
    logic both_pulled_down;
    logic dp_at_high;
    logic dp_at_mid;
    logic dm_at_high;
    logic dm_at_mid;
  } ucdpc_cmp_t;

  // Sources applied to the upstream data pair
  typedef struct packed {
    logic dp_src;
    logic dm_src;
    logic dp_sink;
    logic dm_sink;
  } ucdpc_drive_t;

  typedef enum logic [1:0] {DET_IDLE, DET_SETTLE, DET_DONE} ucdpc_det_state_t;

endpackage : ucdpc_pkg

// [ucdpc_far_model.sv]
// Far-side model: charger on the upstream data pair, loads on the downstream ports.
// Assumes the bench picks the charger profile and which ports carry a faulty load.
`timescale 1ns/1ps
module ucdpc_far_model
  import ucdpc_pkg::*;
(
  // Scenario controls from the bench
  input  wire logic [2:0]   profile,
  input  wire logic [4:1]   fault,
  // Block pins
  input  wire ucdpc_drive_t line_drive,
  input  wire logic [4:1]   port_power_out,
  output ucdpc_cmp_t        cmp_in,
  output logic [4:1]        overcurrent_sense_n
);
  // ****************************************
  // Charger profile on the data pair
  // ****************************************
  always_comb
  begin
    cmp_in = '0;
    case (profile)
      TYPE_DCP:        cmp_in.dp_dm_short      = 1'b1;
      // Reflection exists only while the block sources the positive line
      TYPE_CDP:        cmp_in.dm_reflects_dp   = line_drive.dp_src;
      TYPE_SDP:        cmp_in.both_pulled_down = 1'b1;
      TYPE_PROP_LOW:   {cmp_in.dp_at_mid, cmp_in.dm_at_mid}  = 2'b11;
      TYPE_PROP_HIGH:  {cmp_in.dp_at_mid, cmp_in.dm_at_high} = 2'b11;
      TYPE_PROP_SUPER: {cmp_in.dp_at_high, cmp_in.dm_at_mid} = 2'b11;
      default:         cmp_in = '0;
    endcase
  end

  // ****************************************
  // Loads
  // ****************************************
  // A shorted load only pulls the sense line while its port is powered
  assign overcurrent_sense_n = ~(fault & port_power_out);
endmodule : ucdpc_far_model

// [testbench.sv]
// Self-checking bench for the charger detection and port charging block.
// Assumes a shortened tick of 4 cycles, so one second of retry time is 4000 cycles.
`timescale 1ns/1ps
module testbench;
  import ucdpc_pkg::*;
  localparam int unsigned TICKS = 4;
  logic         core_clk, reset_n, charger_detect_stage, wait_reference_clock_in_stage;
  logic         reference_clock_in_running, hw_init_done, host_connected, ganged_power;
  logic [4:1]   host_port_power, charge_enable_strap, overcurrent_sense_n;
  logic [4:1]   port_power_out, fault;
  ucdpc_cmp_t   cmp_in;
  ucdpc_drive_t line_drive;
  logic         charger_irq, reg_wr;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, rdv;
  logic [2:0]   profile;
  logic [31:0]  lfsr;
  logic [2:0]   types [6];
  int           n_mismatch, n_tests, w;

  ucdpc_top #(.NUM_PORTS(4), .TICK_CYCLES(TICKS)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .charger_detect_stage(charger_detect_stage),
    .wait_reference_clock_in_stage(wait_reference_clock_in_stage), .reference_clock_in_running(reference_clock_in_running),
    .hw_init_done(hw_init_done), .host_connected(host_connected),
    .ganged_power(ganged_power), .host_port_power(host_port_power),
    .charge_enable_strap(charge_enable_strap), .overcurrent_sense_n(overcurrent_sense_n),
    .cmp_in(cmp_in), .line_drive(line_drive), .port_power_out(port_power_out),
    .charger_irq(charger_irq), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  ucdpc_far_model far (.profile(profile), .fault(fault), .line_drive(line_drive),
    .port_power_out(port_power_out), .cmp_in(cmp_in),
    .overcurrent_sense_n(overcurrent_sense_n));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Host presence hands every port to the host; otherwise charging ports stay on
  function automatic logic [4:1] exp_power(input logic [4:1] chg, input logic hc,
                                           input logic [4:1] hpp);
    return hc ? hpp : (hpp | chg);
  endfunction : exp_power

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A wait that runs out of its bound counts as a mismatch and ends the run
  task automatic bound_hit(input logic expired);
    check("wait within bound", expired, 1'b0);
    if (expired)
      stop_test();
  endtask : bound_hit

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr    = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask : rd

  task automatic detect(input logic [2:0] prof, input logic [7:0] ctl,
                        input logic [2:0] exp, input logic via_wait);
    int i;
    profile = prof;
    wr(REG_DET_CTRL, ctl);
    if (via_wait)
      wait_reference_clock_in_stage = 1'b1;
    else
      charger_detect_stage = 1'b1;
    cyc(5);
    check("dp source", line_drive.dp_src, ctl[CTL_EN_BIT]);
    for (i = 0; i < 1000 && charger_irq !== 1'b1; i++)
      cyc(1);
    bound_hit(ctl[CTL_EN_BIT] && i == 1000);
    check("charger irq", charger_irq, ctl[CTL_EN_BIT]);
    rd(REG_STATUS, rdv);
    check("charger type", rdv[2:0], exp);
    check("status flags", rdv[4:3], {2{ctl[CTL_EN_BIT]}});
    charger_detect_stage = 1'b0;
    wait_reference_clock_in_stage    = 1'b0;
    wr(REG_DET_CTRL, ctl | 8'h80);
    check("irq cleared", charger_irq, 1'b0);
  endtask : detect

  // Counts the off time of port 1 after the fault takes it down
  task automatic measure_off(input int exp_len, input logic clear);
    int i;
    int n;
    for (i = 0; i < 200 && port_power_out[1] !== 1'b0; i++)
      cyc(1);
    bound_hit(i == 200);
    if (clear)
      fault = 4'b0000;
    for (n = 0; n < 45000 && port_power_out[1] !== 1'b1; n++)
      cyc(1);
    bound_hit(n == 45000);
    check("off time in range", n >= exp_len - 8 && n <= exp_len + 8, 1'b1);
    check("neighbour power", port_power_out[2], 1'b1);
  endtask : measure_off

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ****************************************
  // Clock
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    lfsr = 32'h981c;
    types = '{TYPE_DCP, TYPE_CDP, TYPE_SDP, TYPE_PROP_LOW, TYPE_PROP_HIGH, TYPE_PROP_SUPER};
    {reset_n, charger_detect_stage, wait_reference_clock_in_stage, hw_init_done} = 4'b0000;
    {reference_clock_in_running, host_connected, ganged_power, reg_wr} = 4'b1000;
    {host_port_power, fault, profile} = 11'h000;
    charge_enable_strap = 4'b0101;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cyc(20);
    reset_n = 1'b1;
    cyc(8);
    rd(REG_CHG_EN, rdv);
    check("strap capture", rdv, 8'h0a);
    rd(REG_DET_CTRL, rdv);
    check("control reset", rdv, DET_CTRL_RESET);
    wr(REG_CHG_EN, 8'h06);
    rd(REG_CHG_EN, rdv);
    check("charge enable", rdv, 8'h06);
    check("power before init", port_power_out, 4'b0000);
    hw_init_done = 1'b1;
    cyc(3);
    check("power after init", port_power_out, exp_power(4'b0011, 1'b0, 4'b0000));
    wr(REG_CHG_EN, 8'h1e);
    rd(REG_CHG_EN, rdv);
    check("locked enable", rdv, 8'h06);
    host_port_power = 4'b1100;
    cyc(2);
    check("mixed ports", port_power_out, exp_power(4'b0011, 1'b0, 4'b1100));
    host_connected = 1'b1;
    repeat (16)
    begin
      lfsr = lfsr_next(lfsr);
      host_port_power = lfsr[3:0];
      cyc(2);
      check("host power", port_power_out, exp_power(4'b0011, 1'b1, lfsr[3:0]));
      rd(8'h05 + {1'b0, lfsr[10:4]}, rdv);
      check("unmapped read", rdv, 8'h00);
    end
    host_port_power = 4'b1111;
    fault = 4'b0001;
    cyc(12);
    check("host owns fault", port_power_out, 4'b1111);
    fault = 4'b0000;
    host_port_power = 4'b0000;
    cyc(10);
    host_connected = 1'b0;
    cyc(10);
    // Detection: disabled, no charger, reflection without enhanced mode, then every code
    detect(TYPE_DCP, 8'h00, TYPE_NONE, 1'b0);
    detect(TYPE_NONE, 8'h01, TYPE_NONE, 1'b0);
    detect(TYPE_CDP, 8'h01, TYPE_NONE, 1'b0);
    foreach (types[k])
      detect(types[k], 8'h03, types[k], 1'b0);
    reference_clock_in_running = 1'b0;
    detect(TYPE_SDP, 8'h05, TYPE_SDP, 1'b1);
    reference_clock_in_running = 1'b1;
    // Custom drive while idle in the config stage, no stage gating
    profile = TYPE_CDP;
    wr(REG_CUSTOM, 8'h1f);
    cyc(4);
    check("custom drive", line_drive, 4'hf);
    rd(REG_COMPARE, rdv);
    check("comparator readback", rdv, 8'h20);
    wr(REG_CUSTOM, 8'h00);
    // Dedicated port fault: three short retries, then the long one
    fault = 4'b0001;
    repeat (3)
      measure_off(1000 * TICKS, 1'b0);
    measure_off(10000 * TICKS, 1'b1);
    cyc(20);
    check("fault cleared", port_power_out, 4'b0011);
    ganged_power = 1'b1;
    fault = 4'b0010;
    cyc(12);
    check("ganged drop", port_power_out[2:1], 2'b00);
    fault = 4'b0000;
    for (w = 0; w < 5000 && port_power_out[1] !== 1'b1; w++)
      cyc(1);
    bound_hit(w == 5000);
    check("ganged return", port_power_out, 4'b0011);
    stop_test();
  end
endmodule : testbench
